//--- rxalc_pkg.sv
package rxalc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_LOOP_ACT    = 8'h43;
  localparam logic [7:0] ADDR_LOOP_DEACT  = 8'h44;
  localparam logic [7:0] ADDR_RX_ALARM    = 8'h45;
  localparam logic [7:0] ADDR_LATCH       = 8'h46;
  localparam logic [7:0] ADDR_COUNT_FIRST = 8'h50;
  localparam logic [7:0] ADDR_COUNT_LAST  = 8'h57;

  // ==========================================================
  // field positions
  localparam int RX_ALARM_CONFIG_FRAME_BIT_INCL = 5;
  localparam int RX_ALARM_CONFIG_EXZ_IN_LCV     = 4;
  localparam int RX_ALARM_CONFIG_YELLOW_INTEGRATION_ENABLE      = 3;
  localparam int RX_ALARM_CONFIG_LOF_INTEG      = 2;
  localparam int RX_ALARM_CONFIG_FORCE_ONES     = 0;
  localparam int LATCH_FREEZE        = 3;
  localparam int LATCH_COUNTERS      = 2;
  localparam int LATCH_ERRORS        = 1;
  localparam int LATCH_ALARMS        = 0;

  // ==========================================================
  // write masks and reset values
  localparam logic [7:0] PATTERN_MASK   = 8'hfe;
  localparam logic [7:0] RX_ALARM_CONFIG_MASK      = 8'h3d;
  localparam logic [7:0] LATCH_MASK     = 8'h0f;
  localparam logic [7:0] LOOP_ACT_RST   = 8'h00;
  localparam logic [7:0] LOOP_DEACT_RST = 8'h00;
  localparam logic [7:0] RX_ALARM_CONFIG_RST       = 8'h00;
  localparam logic [7:0] LATCH_RST      = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_HZ            = 25000000;
  localparam int LOOP_PERIOD_MS    = 24;
  localparam int LOOP_PERIOD_CYC   = CLK_HZ / 1000 * LOOP_PERIOD_MS;
  localparam int ONE_SECOND_CYC    = CLK_HZ;
  localparam int LOF_INTEG_MIN_MS  = 2000;
  localparam int LOF_INTEG_MAX_MS  = 2500;
  localparam int LOF_INTEG_CYC     = CLK_HZ / 1000 * LOF_INTEG_MIN_MS;
  localparam int TIMER_W           = 26;

  // ==========================================================
  // thresholds
  localparam logic [6:0] LOOP_DETECT_ERR = 7'h3f;
  localparam logic [6:0] LOOP_DROP_ERR   = 7'h40;
  localparam logic [4:0] EXZ_RUN_SHORT   = 5'h08;
  localparam logic [4:0] EXZ_RUN_LONG    = 5'h10;
  localparam logic [2:0] CODE_LEN_BASE   = 3'h3;

endpackage

//--- rxalc_loop_det.sv
`timescale 1ns/10ps
`default_nettype none
module rxalc_loop_det (
  // clock
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // receive stream
  input  wire logic       bit_valid,
  input  wire logic       bit_in,
  input  wire logic       bit_is_fbit,
  // code setup
  input  wire logic [6:0] pattern,
  input  wire logic [1:0] code_len,
  input  wire logic       period_end,
  // result
  output logic            detected
);

  logic [2:0] pos_q;
  logic [2:0] pos_d;
  logic [6:0] err_q;
  logic [6:0] err_d;
  logic       det_d;
  logic       slip_q;
  logic       slip_d;

  // ==========================================================
  // pattern compare
  wire [2:0] last_pos = {1'b0, code_len} + rxalc_pkg::CODE_LEN_BASE;
  wire [2:0] pidx     = 3'h6 - pos_q;
  wire       expected = pattern[pidx];
  wire       step     = bit_valid & ~bit_is_fbit;
  wire       bit_err  = step & (bit_in != expected);
  wire       err_sat  = &err_q;
  wire       misalign = ~detected & (err_q >= rxalc_pkg::LOOP_DROP_ERR);

  assign pos_d  = (step & ~slip_q) ?
                  ((pos_q == last_pos) ? 3'h0 : pos_q + 3'h1) : pos_q;
  // slip one bit after a bad period to hunt the code phase
  assign slip_d = period_end ? misalign : (slip_q & ~step);
  assign err_d  = period_end ? {6'h00, bit_err} :
                  ((bit_err & ~err_sat) ? err_q + 7'h01 : err_q);
  assign det_d  = ~period_end ? detected :
                  (err_q < rxalc_pkg::LOOP_DETECT_ERR) ? 1'b1 :
                  (err_q >= rxalc_pkg::LOOP_DROP_ERR) ? 1'b0 : detected;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pos_q    <= 3'h0;
      err_q    <= 7'h00;
      slip_q   <= 1'b0;
      detected <= 1'b0;
    end else if (clk_en) begin
      pos_q    <= pos_d;
      err_q    <= err_d;
      slip_q   <= slip_d;
      detected <= det_d;
    end
  end

  // ==========================================================
  // checks
  loop_detect_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && period_end && err_q < 7'h3f |=> detected)
    else $error("loop code not declared under 63 errors");

  loop_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && period_end && err_q >= 7'h40 |=> !detected)
    else $error("loop code kept after 64 errors");

endmodule
`default_nettype wire

//--- rxalc_top.sv
`timescale 1ns/10ps
`default_nettype none
module rxalc_top #(
  parameter int LOOP_PERIOD_CYCLES = rxalc_pkg::LOOP_PERIOD_CYC,
  parameter int ONE_SECOND_CYCLES  = rxalc_pkg::ONE_SECOND_CYC,
  parameter int LOF_INTEG_CYCLES   = rxalc_pkg::LOF_INTEG_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // host register port
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  output logic      [7:0] host_rdata,
  // framer modes
  input  wire logic       e1_mode,
  input  wire logic       japanese_yellow_mode,
  input  wire logic       rx_zero_substitution_select,
  input  wire logic [1:0] activate_code_length,
  input  wire logic [1:0] deactivate_code_length,
  // receive data
  input  wire logic       rx_bit_valid,
  input  wire logic       rx_bit,
  input  wire logic       rx_fbit,
  input  wire logic       rx_pcm_data,
  output logic            rx_pcm_output,
  // loopback code detection
  output logic            loop_activate_detected,
  output logic            loop_deactivate_detected,
  // error events in
  input  wire logic       fas_bit_error,
  input  wire logic       fs_bit_error,
  input  wire logic       fs_in_frame12,
  input  wire logic       bipolar_violation,
  input  wire logic       pattern_bit_error,
  input  wire logic       alarm_event,
  // counter increments out
  output logic            frame_error_inc,
  output logic            frame_loss_crit_error,
  output logic            line_violation_inc,
  output logic            excess_zeros_event,
  output logic            pattern_error_inc,
  output logic            alarm_event_inc,
  // alarms in
  input  wire logic       rx_frame_loss_raw,
  input  wire logic       rx_signal_loss,
  input  wire logic       rx_all_ones_alarm,
  input  wire logic       rx_frame_yellow_rt,
  input  wire logic       rx_frame_yellow_int,
  input  wire logic       rx_multiframe_yellow_rt,
  input  wire logic       rx_multiframe_yellow_int,
  // alarms out
  output logic            rx_frame_yellow,
  output logic            rx_multiframe_yellow,
  output logic            rx_frame_loss,
  output logic            framer_status_frame_loss,
  // counter latch control
  output logic            one_second_tick,
  output logic            count_latch_strobe,
  output logic            error_count_hold,
  output logic            error_second_latch,
  output logic            alarm_second_latch,
  output logic            count_low_read,
  output logic            count_high_read,
  output logic      [1:0] count_read_pair
);

  localparam int TW = rxalc_pkg::TIMER_W;

  logic [7:0]    loop_act_q;
  logic [7:0]    loop_deact_q;
  logic [7:0]    rx_alarm_config_q;
  logic [7:0]    latch_q;
  logic [TW-1:0] sec_cnt_q;
  logic [TW-1:0] per_cnt_q;
  logic [TW-1:0] lof_cnt_q;
  logic          lof_integ_q;
  logic [4:0]    zero_run_q;
  logic          loop_period_q;
  logic          act_det;
  logic          deact_det;

  // ==========================================================
  // register decode
  wire sel_act    = host_addr == rxalc_pkg::ADDR_LOOP_ACT;
  wire sel_deact  = host_addr == rxalc_pkg::ADDR_LOOP_DEACT;
  wire sel_rx_alarm_config   = host_addr == rxalc_pkg::ADDR_RX_ALARM;
  wire sel_latch  = host_addr == rxalc_pkg::ADDR_LATCH;
  wire sel_count  = (host_addr >= rxalc_pkg::ADDR_COUNT_FIRST) &&
                    (host_addr <= rxalc_pkg::ADDR_COUNT_LAST);
  wire wr_ok      = clk_en & host_wr;

  wire [7:0] rd_mux = sel_act   ? loop_act_q   :
                      sel_deact ? loop_deact_q :
                      sel_rx_alarm_config  ? rx_alarm_config_q       :
                      sel_latch ? latch_q      : 8'h00;

  // ==========================================================
  // configuration fields
  wire frame_bit_inclusion            = rx_alarm_config_q[rxalc_pkg::RX_ALARM_CONFIG_FRAME_BIT_INCL];
  wire excess_zero_in_violation_count = rx_alarm_config_q[rxalc_pkg::RX_ALARM_CONFIG_EXZ_IN_LCV];
  wire yellow_integration_enable      = rx_alarm_config_q[rxalc_pkg::RX_ALARM_CONFIG_YELLOW_INTEGRATION_ENABLE];
  wire frame_loss_integration_enable  = rx_alarm_config_q[rxalc_pkg::RX_ALARM_CONFIG_LOF_INTEG];
  wire rx_pcm_force_ones              = rx_alarm_config_q[rxalc_pkg::RX_ALARM_CONFIG_FORCE_ONES];
  wire freeze_counts_on_alarm         = latch_q[rxalc_pkg::LATCH_FREEZE];
  wire counter_second_latch           = latch_q[rxalc_pkg::LATCH_COUNTERS];

  // ==========================================================
  // timers
  wire tick_d   = sec_cnt_q == TW'(ONE_SECOND_CYCLES - 1);
  wire period_d = per_cnt_q == TW'(LOOP_PERIOD_CYCLES - 1);
  wire [TW-1:0] sec_cnt_d = tick_d   ? '0 : sec_cnt_q + TW'(1);
  wire [TW-1:0] per_cnt_d = period_d ? '0 : per_cnt_q + TW'(1);

  // ==========================================================
  // frame error qualification
  wire fs_counted  = fs_bit_error &
                     ~(japanese_yellow_mode & fs_in_frame12);
  wire frame_err_d = fas_bit_error |
                     (frame_bit_inclusion & fs_counted);

  // ==========================================================
  // excess zeros
  wire [4:0] exz_limit  = rx_zero_substitution_select ?
                          rxalc_pkg::EXZ_RUN_SHORT :
                          rxalc_pkg::EXZ_RUN_LONG;
  wire       zero_bit   = rx_bit_valid & ~rx_bit;
  wire [4:0] run_next   = (&zero_run_q) ? zero_run_q : zero_run_q + 5'h01;
  wire [4:0] zero_run_d = ~rx_bit_valid ? zero_run_q :
                          zero_bit ? run_next : 5'h00;
  wire       exz_d      = zero_bit & (run_next == exz_limit) &
                          (zero_run_q != exz_limit);

  // ==========================================================
  // counter freezing and latching
  wire hold_d  = freeze_counts_on_alarm &
                 (rx_frame_loss_raw | rx_signal_loss |
                  rx_all_ones_alarm);
  wire lcv_d   = (bipolar_violation |
                  (excess_zero_in_violation_count & exz_d)) &
                 ~hold_d;
  wire latch_eff  = counter_second_latch | e1_mode;
  wire strobe_d   = tick_d & latch_eff;
  wire cnt_rd     = clk_en & host_rd & sel_count & ~latch_eff;
  wire low_rd_d   = cnt_rd & ~host_addr[0];
  wire high_rd_d  = cnt_rd & host_addr[0];

  // ==========================================================
  // frame loss integration, T1 only
  wire lof_differs = rx_frame_loss_raw != lof_integ_q;
  wire lof_flip    = lof_differs &
                     (lof_cnt_q == TW'(LOF_INTEG_CYCLES - 1));
  wire [TW-1:0] lof_cnt_d = (lof_differs & ~lof_flip) ?
                            lof_cnt_q + TW'(1) : '0;
  wire lof_integ_d = lof_flip ? rx_frame_loss_raw : lof_integ_q;
  wire lof_out_d   = (frame_loss_integration_enable & ~e1_mode) ?
                     lof_integ_q : rx_frame_loss_raw;

  // ==========================================================
  // alarm report selection
  wire rx_frame_yellow_d  = yellow_integration_enable ?
                 rx_frame_yellow_int : rx_frame_yellow_rt;
  wire rx_multiframe_yellow_d = yellow_integration_enable ?
                 rx_multiframe_yellow_int :
                 rx_multiframe_yellow_rt;
  wire pcm_d   = rx_pcm_force_ones | rx_pcm_data;

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      loop_act_q   <= rxalc_pkg::LOOP_ACT_RST;
      loop_deact_q <= rxalc_pkg::LOOP_DEACT_RST;
      rx_alarm_config_q       <= rxalc_pkg::RX_ALARM_CONFIG_RST;
      latch_q      <= rxalc_pkg::LATCH_RST;
    end else if (wr_ok) begin
      if (sel_act) begin
        loop_act_q <= host_wdata & rxalc_pkg::PATTERN_MASK;
      end
      if (sel_deact) begin
        loop_deact_q <= host_wdata & rxalc_pkg::PATTERN_MASK;
      end
      // bit 1 has no function and is stored as zero
      if (sel_rx_alarm_config) begin
        rx_alarm_config_q <= host_wdata & rxalc_pkg::RX_ALARM_CONFIG_MASK;
      end
      if (sel_latch) begin
        latch_q <= host_wdata & rxalc_pkg::LATCH_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      host_rdata <= 8'h00;
    end else if (clk_en && host_rd) begin
      host_rdata <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sec_cnt_q     <= '0;
      per_cnt_q     <= '0;
      lof_cnt_q     <= '0;
      lof_integ_q   <= 1'b0;
      zero_run_q    <= 5'h00;
      loop_period_q <= 1'b0;
    end else if (clk_en) begin
      sec_cnt_q     <= sec_cnt_d;
      per_cnt_q     <= per_cnt_d;
      lof_cnt_q     <= lof_cnt_d;
      lof_integ_q   <= lof_integ_d;
      zero_run_q    <= zero_run_d;
      loop_period_q <= period_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_pcm_output            <= 1'b0;
      frame_error_inc          <= 1'b0;
      frame_loss_crit_error    <= 1'b0;
      line_violation_inc       <= 1'b0;
      excess_zeros_event       <= 1'b0;
      pattern_error_inc        <= 1'b0;
      alarm_event_inc          <= 1'b0;
    end else if (clk_en) begin
      rx_pcm_output            <= pcm_d;
      frame_error_inc          <= frame_err_d & ~hold_d;
      frame_loss_crit_error    <= frame_err_d;
      line_violation_inc       <= lcv_d;
      excess_zeros_event       <= exz_d;
      pattern_error_inc        <= pattern_bit_error;
      alarm_event_inc          <= alarm_event;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_frame_yellow          <= 1'b0;
      rx_multiframe_yellow     <= 1'b0;
      rx_frame_loss            <= 1'b0;
      framer_status_frame_loss <= 1'b0;
      one_second_tick          <= 1'b0;
      count_latch_strobe       <= 1'b0;
      error_count_hold         <= 1'b0;
      error_second_latch       <= 1'b0;
      alarm_second_latch       <= 1'b0;
      count_low_read           <= 1'b0;
      count_high_read          <= 1'b0;
      count_read_pair          <= 2'h0;
    end else if (clk_en) begin
      rx_frame_yellow          <= rx_frame_yellow_d;
      rx_multiframe_yellow     <= rx_multiframe_yellow_d;
      rx_frame_loss            <= lof_out_d;
      framer_status_frame_loss <= rx_frame_loss_raw;
      one_second_tick          <= tick_d;
      count_latch_strobe       <= strobe_d;
      error_count_hold         <= hold_d;
      error_second_latch       <= latch_q[rxalc_pkg::LATCH_ERRORS];
      alarm_second_latch       <= latch_q[rxalc_pkg::LATCH_ALARMS];
      count_low_read           <= low_rd_d;
      count_high_read          <= high_rd_d;
      count_read_pair          <= host_addr[2:1];
    end
  end

  // ==========================================================
  // loopback code detectors
  rxalc_loop_det u_activate (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .clk_en      (clk_en),
    .bit_valid   (rx_bit_valid),
    .bit_in      (rx_bit),
    .bit_is_fbit (rx_fbit),
    .pattern     (loop_act_q[7:1]),
    .code_len    (activate_code_length),
    .period_end  (loop_period_q),
    .detected    (act_det)
  );

  rxalc_loop_det u_deactivate (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .clk_en      (clk_en),
    .bit_valid   (rx_bit_valid),
    .bit_in      (rx_bit),
    .bit_is_fbit (rx_fbit),
    .pattern     (loop_deact_q[7:1]),
    .code_len    (deactivate_code_length),
    .period_end  (loop_period_q),
    .detected    (deact_det)
  );

  assign loop_activate_detected   = act_det;
  assign loop_deactivate_detected = deact_det;

  // ==========================================================
  // checks
  sequence force_seen_s;
    clk_en && rx_pcm_force_ones;
  endsequence

  pcm_force_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    force_seen_s |=> rx_pcm_output)
    else $error("receive pcm output not forced to ones");

  pcm_pass_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && !rx_pcm_force_ones |=> rx_pcm_output == $past(rx_pcm_data))
    else $error("receive pcm data not passed");

  count_freeze_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && hold_d |=> !line_violation_inc && !frame_error_inc)
    else $error("error count advanced during alarm");

  pattern_free_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en |=> pattern_error_inc == $past(pattern_bit_error))
    else $error("pattern error increment suppressed");

  frame_incl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && !frame_bit_inclusion && !fas_bit_error
    |=> !frame_error_inc && !frame_loss_crit_error)
    else $error("frame-bit error counted while excluded");

  lcv_exz_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && exz_d && excess_zero_in_violation_count && !hold_d
    |=> line_violation_inc && excess_zeros_event)
    else $error("excess zeros not added to violations");

  yellow_integration_enable_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && yellow_integration_enable
    |=> rx_frame_yellow == $past(rx_frame_yellow_int) &&
        rx_multiframe_yellow == $past(rx_multiframe_yellow_int))
    else $error("yellow alarm not integrated form");

  lof_e1_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && e1_mode |=> rx_frame_loss == $past(rx_frame_loss_raw))
    else $error("frame loss integrated in E1 mode");

  raw_status_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en |=> framer_status_frame_loss == $past(rx_frame_loss_raw))
    else $error("raw framer status altered");

  latch_tick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    count_latch_strobe |-> one_second_tick)
    else $error("latch strobe outside one-second tick");

  e1_latch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && tick_d && e1_mode |=> count_latch_strobe)
    else $error("E1 mode did not latch counters");

  tick_single_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && one_second_tick |=> !one_second_tick)
    else $error("one-second tick longer than a cycle");

  low_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && host_rd && host_addr == 8'h50 && !latch_eff
    |=> count_low_read && !count_high_read)
    else $error("low byte read did not signal copy");

endmodule
`default_nettype wire

//--- rxalc_host.sv
`timescale 1ns/10ps
`default_nettype none
module rxalc_host (
  // register port
  input  wire logic       clk_sys,
  output logic      [7:0] host_addr,
  output logic      [7:0] host_wdata,
  output logic            host_wr,
  output logic            host_rd,
  input  wire logic [7:0] host_rdata
);
  // ==========================================================
  // host byte cycles
  initial begin
    host_addr = 8'h00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    host_addr  <= a;
    host_wdata <= (a == 8'h45) ? (v & 8'hfd) : v;
    host_wr    <= 1'b1;
    @(posedge clk_sys);
    host_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    host_addr <= a;
    host_rd   <= 1'b1;
    @(posedge clk_sys);
    host_rd   <= 1'b0;
    @(negedge clk_sys);
    v = host_rdata;
  endtask
endmodule
`default_nettype wire

//--- rxalc_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module rxalc_top_test;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        e1, jy, zcs, bv, rb, hwr, hrd;
  logic [1:0]  pair;
  logic [13:0] p, q;
  logic [7:0]  ha, hw, hr, d, c, l;
  logic        pco, lad, ldd, fcr, lvi, eze, pei, aei, ry, rmy, rfl, fsl;
  logic        tick, cls, hold, esl, asl, clr, chr;
  logic        en, fb, fei;
  int          n_fail = 0, n_checks = 0, seed = 17177, cyc = 0, last = -1;
  int          k, i, nz, nl;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + int'(en);
  rxalc_host host (.clk_sys(clk_sys), .host_addr(ha), .host_wdata(hw),
    .host_wr(hwr), .host_rd(hrd), .host_rdata(hr));
  rxalc_top #(.LOOP_PERIOD_CYCLES(64), .ONE_SECOND_CYCLES(32),
    .LOF_INTEG_CYCLES(16)) uut (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(en), .host_addr(ha),
    .host_wdata(hw), .host_wr(hwr), .host_rd(hrd), .host_rdata(hr),
    .e1_mode(e1), .japanese_yellow_mode(jy),
    .rx_zero_substitution_select(zcs), .activate_code_length(2'h3),
    .deactivate_code_length(2'h0), .rx_bit_valid(bv), .rx_bit(rb),
    .rx_fbit(fb), .rx_pcm_data(p[0]), .rx_pcm_output(pco),
    .loop_activate_detected(lad), .loop_deactivate_detected(ldd),
    .fas_bit_error(p[12]), .fs_bit_error(p[10]), .fs_in_frame12(p[11]),
    .bipolar_violation(p[13]), .pattern_bit_error(p[1]),
    .alarm_event(p[2]), .frame_error_inc(fei), .frame_loss_crit_error(fcr),
    .line_violation_inc(lvi), .excess_zeros_event(eze),
    .pattern_error_inc(pei), .alarm_event_inc(aei),
    .rx_frame_loss_raw(p[3]), .rx_signal_loss(p[4]),
    .rx_all_ones_alarm(p[5]), .rx_frame_yellow_rt(p[6]),
    .rx_frame_yellow_int(p[7]), .rx_multiframe_yellow_rt(p[8]),
    .rx_multiframe_yellow_int(p[9]), .rx_frame_yellow(ry),
    .rx_multiframe_yellow(rmy), .rx_frame_loss(rfl),
    .framer_status_frame_loss(fsl), .one_second_tick(tick),
    .count_latch_strobe(cls), .error_count_hold(hold),
    .error_second_latch(esl), .alarm_second_latch(asl),
    .count_low_read(clr), .count_high_read(chr), .count_read_pair(pair));
  // ==========================================================
  // checking and closing
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic feed(input logic b, input int n);
    nz = 0;
    nl = 0;
    repeat (n) begin
      @(posedge clk_sys);
      bv <= 1'b1;
      rb <= b;
      @(negedge clk_sys);
      nz += int'(eze);
      nl += int'(lvi);
    end
  endtask
  always @(negedge clk_sys) begin
    if (resetn && tick && cyc != last) begin
      if (last >= 0) chk("tick_gap", 8'(cyc - last), 8'h20);
      last = cyc;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {e1, jy, zcs, bv, rb} = 5'h00;
    {en, fb} = 2'h2;
    p = 14'h0000;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      host.rd(8'h43 + 8'(i), d);
      chk("reset_value", d, 8'h00);
    end
    for (i = 0; i < 5; i++) host.wr(8'h43 + 8'(i), 8'hff);
    for (i = 0; i < 5; i++) begin
      host.rd(8'h43 + 8'(i), d);
      chk("reg_access", d, 8'(40'h000f3dfefe >> (8 * i)));
    end
    for (k = 0; k < 4; k++) begin
      c = 8'($random(seed)) & 8'h3d;
      l = 8'($random(seed)) & 8'h0f;
      host.wr(8'h45, c);
      host.wr(8'h46, l);
      e1 <= k[0];
      jy <= k[1] & ~k[0];
      for (i = 0; i < 200; i++) begin
        @(posedge clk_sys);
        q = p;
        p <= 14'($random(seed));
        @(negedge clk_sys);
        if (i > 1) begin
          chk("datapath", {pco, pei, aei, fsl, hold, ry, rmy, esl},
            {c[0] | q[0], q[1], q[2], q[3], l[3] & (|q[5:3]),
             c[3] ? q[7] : q[6], c[3] ? q[9] : q[8], l[1]});
          chk("control", 8'({asl, cls, rfl & (e1 | ~c[2]), fcr & ~q[12]}),
            8'({l[0], tick & (l[2] | e1), q[3] & (e1 | ~c[2]),
             q[10] & c[5] & ~(jy & q[11]) & ~q[12]}));
          chk("counts", 8'({fei, lvi, eze}),
            8'({(q[12] | (c[5] & q[10] & ~(jy & q[11]))) &
             ~(l[3] & (|q[5:3])), q[13] & ~(l[3] & (|q[5:3])),
             1'b0}));
        end
      end
    end
    p <= 14'h0000;
    e1 <= 1'b0;
    host.wr(8'h46, 8'h00);
    host.rd(8'h52, d);
    chk("low_read", 8'({clr, chr, pair}), 8'h09);
    host.rd(8'h53, d);
    chk("high_read", 8'({clr, chr, pair}), 8'h05);
    host.wr(8'h46, 8'h04);
    host.rd(8'h53, d);
    chk("latched_read", 8'({clr, chr}), 8'h00);
    host.wr(8'h45, 8'h04);
    p <= 14'h0008;
    repeat (8) @(negedge clk_sys);
    chk("lof_early", 8'(rfl), 8'h00);
    repeat (20) @(negedge clk_sys);
    chk("lof_late", 8'(rfl), 8'h01);
    en <= 1'b0;
    p <= 14'h0001;
    repeat (4) @(negedge clk_sys);
    chk("clock_enable", 8'({pco, rfl}), 8'h01);
    en <= 1'b1;
    host.wr(8'h45, 8'h10);
    p <= 14'h0000;
    zcs <= 1'b1;
    feed(1'b1, 4);
    feed(1'b0, 20);
    chk("exz_run8", 8'(nz * 16 + nl), 8'h11);
    zcs <= 1'b0;
    feed(1'b1, 4);
    feed(1'b0, 12);
    chk("exz_run16", 8'(nz), 8'h00);
    feed(1'b0, 8);
    chk("exz_run16b", 8'(nz), 8'h01);
    host.wr(8'h43, 8'hfe);
    host.wr(8'h44, 8'h00);
    feed(1'b1, 320);
    chk("loop_ones", 8'({lad, ldd}), 8'h02);
    fb <= 1'b1;
    feed(1'b0, 200);
    chk("loop_fbit", 8'({lad, ldd}), 8'h03);
    fb <= 1'b0;
    feed(1'b0, 320);
    chk("loop_zeros", 8'({lad, ldd}), 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
